// ==== src/scsr_top.sv ====
// System control status registers: basic status, error information and
// per-secondary-unit status, reached by programmed I/O requests.
// Assumes requests last one cycle and are synchronous to ref_clk_in.
//
// Contract
// - Power-on reset sets power-restored flag
// - Bit 7 on sends all accesses to processor storage
// - Bit 7 off: fetch/read below 4K from ROM
// - Timer enable or 100 ms tick sets bit 8
// - Only program sets bit 9; rise sets 8
// - Expansion power loss sets bit 11, and 15
// - Halt on 08 or panels sets bit 13
// - Bit 14 gates interrupt; program-only set
// - Bits 8, 9, 11 set request bit 15
// - Error bit 1 selects level 0, else 3
// - Read parity fault sets error bit 4
// - Missed 100 ms interrupt sets timer check
// - Write or command parity sets bit 9
// - Secondary error sets error bit 11
// - Faults on address 0C set error bit 13
// - Secondary bit 0 grants device access
// - Secondary error events set its bit 2
// - Secondary bit 2 blocks transfers, propagates up
// - Secondary bit 3 off allows writes only
`timescale 1ns/1ps
`default_nettype none
module scsr_top import scsr_pkg::*; #(
	parameter int TICK_LEN = TICK_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Programmed I/O
	input wire scsr_pio_req_t pio_in,
	output logic pio_ack_out,
	output logic pio_refused_out,
	output logic [15:0] pio_rdata_out,
	// Hardware events
	input wire logic sys_reset_in,
	input wire logic exp_power_lost_in,
	input wire logic panel_halt_in,
	input wire logic panel_rd_perr_in,
	input wire logic panel_wr_perr_in,
	input wire logic [NUM_SEC-1:0] sec_array_perr_in,
	// Storage access routing
	input wire logic mem_req_in,
	input wire logic mem_write_in,
	input wire logic [15:0] mem_addr_in,
	output logic mem_valid_out,
	output logic mem_rom_sel_out,
	// Status and interrupt
	output logic irq_out,
	output logic [1:0] prio_level_out,
	output logic [15:0] basic_status_out,
	output logic [15:0] error_information_out,
	output logic [NUM_SEC-1:0] sec_group_enable_out
);
	// ************************************************
	// Reset release
	// ************************************************
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ************************************************
	// Decode
	// ************************************************
	logic [15:0] basic_status;
	logic [15:0] error_information;
	logic [7:0] sec_status [NUM_SEC];
	logic [NUM_SEC-1:0] sec_ok;
	logic [NUM_SEC-1:0] sec_hit;
	logic tick;
	wire logic is_read = pio_in.cmd == CMD_READ;
	wire logic hit_basic = pio_in.valid && pio_in.addr == ADDR_BASIC;
	wire logic hit_err = pio_in.valid && pio_in.addr == ADDR_ERR;
	wire logic any_sec = |sec_hit;
	wire logic cmd_bad = pio_in.cmd_perr || pio_in.cmd > CMD_RESET;
	wire logic rd_fault = is_read && pio_in.rd_perr;
	wire logic wr_fault = pio_in.cmd_perr || (!is_read && pio_in.wr_perr);
	wire logic prog_basic = hit_basic && !cmd_bad && !wr_fault && !is_read;
	wire logic prog_err = hit_err && !cmd_bad && !wr_fault && !is_read;

	// ************************************************
	// Secondary units
	// ************************************************
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SEC; gi++) begin : g_sec
			assign sec_hit[gi] = pio_in.valid && pio_in.addr == ADDR_SEC_BASE + 8'(gi);
			scsr_sec_unit u_sec (
				.clk_in(ref_clk_in),
				.rst_n_in(rst_n),
				.acc_in(sec_hit[gi]),
				.req_in(pio_in),
				.array_perr_in(sec_array_perr_in[gi]),
				.status_out(sec_status[gi]),
				.ok_out(sec_ok[gi])
			);
		end
	endgenerate
	logic [NUM_SEC-1:0] sec_err_on;
	logic [NUM_SEC-1:0] sec_grp_on;
	logic [7:0] sec_rd;
	always_comb begin
		sec_rd = 8'h00;
		for (int i = 0; i < NUM_SEC; i++) begin
			sec_err_on[i] = sec_status[i][SU_ERR];
			sec_grp_on[i] = sec_status[i][SU_GRP];
			if (sec_hit[i]) begin
				sec_rd = sec_status[i];
			end
		end
	end

	// ************************************************
	// Basic status
	// ************************************************
	wire logic [15:0] basic_prog = apply_cmd(basic_status, pio_in.cmd, pio_in.data) & BASIC_MASK;
	wire logic [15:0] basic_base = prog_basic ? basic_prog : basic_status;
	// Bit 9 only rises by program write; that rise raises bit 8
	wire logic ten_rise = prog_basic && basic_prog[BS_TEN] && !basic_status[BS_TEN];
	wire logic set_tint = ten_rise || (tick && basic_status[BS_TEN]);
	wire logic set_eq = panel_halt_in || (hit_basic && (pio_in.halt || rd_fault
		|| wr_fault));
	wire logic prog_req = prog_basic && ((basic_prog[BS_TINT] && !basic_status[BS_TINT])
		|| (basic_prog[BS_EXPPWR] && !basic_status[BS_EXPPWR]));
	wire logic set_req = set_tint || ten_rise || exp_power_lost_in || prog_req;
	wire logic [15:0] basic_hwclr = sys_reset_in ? 16'(1 << BS_PSEL) | 16'(1 << BS_TEN)
		| 16'(1 << BS_EQCHK) | 16'(1 << BS_IEN) | 16'(1 << BS_IREQ) : 16'h0000;
	wire logic [15:0] basic_hwset = (set_tint ? 16'(1 << BS_TINT) : 16'h0000)
		| (exp_power_lost_in ? 16'(1 << BS_EXPPWR) : 16'h0000)
		| (set_eq ? 16'(1 << BS_EQCHK) : 16'h0000)
		| (set_req ? 16'(1 << BS_IREQ) : 16'h0000);
	// Hardware sets win over any clear in the same cycle
	wire logic [15:0] next_basic = (basic_base & ~basic_hwclr) | basic_hwset;

	// ************************************************
	// Error information
	// ************************************************
	wire logic [15:0] err_prog = apply_cmd(error_information, pio_in.cmd, pio_in.data) & ERR_MASK;
	wire logic [15:0] err_base = prog_err ? err_prog : error_information;
	wire logic any_map = hit_basic || hit_err;
	wire logic set_rdchk = panel_rd_perr_in || (any_map && rd_fault);
	wire logic set_wrchk = panel_wr_perr_in || (any_map && wr_fault);
	// A tick that finds the previous interrupt still pending was missed
	wire logic set_tchk = tick && basic_status[BS_TEN] && basic_status[BS_TINT];
	wire logic set_secchk = |sec_err_on;
	wire logic set_adchk = hit_err && (pio_in.halt || rd_fault || wr_fault);
	wire logic [15:0] err_hwclr = sys_reset_in ? 16'(1 << EI_PRIO) | 16'(1 << EI_TCHK)
		| 16'(1 << EI_WRCHK) | 16'(1 << EI_ADCHK) : 16'h0000;
	wire logic [15:0] err_hwset = (set_rdchk ? 16'(1 << EI_RDCHK) : 16'h0000)
		| (set_tchk ? 16'(1 << EI_TCHK) : 16'h0000)
		| (set_wrchk ? 16'(1 << EI_WRCHK) : 16'h0000)
		| (set_secchk ? 16'(1 << EI_SECCHK) : 16'h0000)
		| (set_adchk ? 16'(1 << EI_ADCHK) : 16'h0000);
	wire logic [15:0] next_err = (err_base & ~err_hwclr) | err_hwset;

	// ************************************************
	// Answers, routing and status outputs
	// ************************************************
	wire logic refused = pio_in.valid && !((any_map && !cmd_bad && !wr_fault && !rd_fault)
		|| |sec_ok);
	wire logic [15:0] next_rdata = !(is_read && pio_in.valid) ? 16'h0000
		: hit_basic ? basic_status : hit_err ? error_information
		: |sec_ok ? {8'h00, sec_rd} : 16'h0000;
	wire logic rom_sel = mem_req_in && !basic_status[BS_PSEL] && !mem_write_in
		&& mem_addr_in < ROM_LIMIT;
	wire logic [1:0] next_prio = error_information[EI_PRIO] ? PRIO_HIGH : PRIO_LOW;

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			basic_status <= BASIC_RESET;
			error_information <= ERR_RESET;
		end else begin
			basic_status <= next_basic;
			error_information <= next_err;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pio_ack_out <= 1'b0;
			pio_refused_out <= 1'b0;
			pio_rdata_out <= 16'h0000;
			mem_valid_out <= 1'b0;
			mem_rom_sel_out <= 1'b0;
		end else begin
			pio_ack_out <= pio_in.valid;
			pio_refused_out <= refused;
			pio_rdata_out <= next_rdata;
			mem_valid_out <= mem_req_in;
			mem_rom_sel_out <= rom_sel;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_out <= 1'b0;
			prio_level_out <= PRIO_LOW;
			basic_status_out <= BASIC_RESET;
			error_information_out <= ERR_RESET;
			sec_group_enable_out <= '0;
		end else begin
			irq_out <= next_basic[BS_IREQ] && next_basic[BS_IEN];
			prio_level_out <= next_prio;
			basic_status_out <= next_basic;
			error_information_out <= next_err;
			sec_group_enable_out <= sec_grp_on;
		end
	end

	scsr_tick #(
		.CYCLES(TICK_LEN)
	) u_tick (
		.clk_in(ref_clk_in),
		.rst_n_in(rst_n),
		.run_in(basic_status[BS_TEN]),
		.tick_out(tick)
	);

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n);

	sequence s_ten_write;
		prog_basic && basic_prog[BS_TEN] && !basic_status[BS_TEN];
	endsequence
	sequence s_tint_and_req;
		basic_status[BS_TINT] && basic_status[BS_IREQ];
	endsequence
	AST_TEN_RISE: assert property (s_ten_write |=> s_tint_and_req)
		else $error("Timer enable rise did not raise interrupt bits");
	AST_TICK: assert property (tick && basic_status[BS_TEN] |=> basic_status[BS_TINT])
		else $error("Timer tick lost");
	AST_TEN_ONLY_PROG: assert property ($rose(basic_status[BS_TEN])
		|-> $past(prog_basic))
		else $error("Timer enable rose without program");
	AST_EXP_PWR: assert property (exp_power_lost_in |=> basic_status[BS_EXPPWR]
		&& basic_status[BS_IREQ])
		else $error("Power loss not flagged");
	AST_IRQ_GATE: assert property (irq_out
		|-> basic_status[BS_IEN] && basic_status[BS_IREQ])
		else $error("Interrupt without enable");
	AST_PRIO: assert property (##1 prio_level_out ==
		($past(error_information[EI_PRIO]) ? PRIO_HIGH : PRIO_LOW))
		else $error("Wrong priority level");
	AST_ROM: assert property (mem_req_in && basic_status[BS_PSEL] |=> !mem_rom_sel_out)
		else $error("ROM selected with storage select on");
	AST_ROM_WRITE: assert property (mem_write_in |=> !mem_rom_sel_out)
		else $error("Write routed to ROM");
	AST_SEC_PROP: assert property (|sec_err_on |=> error_information[EI_SECCHK])
		else $error("Secondary error not propagated");
	AST_RSVD: assert property ((basic_status & ~BASIC_MASK) == 16'h0000
		&& (error_information & ~ERR_MASK) == 16'h0000)
		else $error("Reserved bit set");
	AST_ADCHK: assert property (hit_err && pio_in.halt |=> error_information[EI_ADCHK])
		else $error("Halt on 0C not flagged");

	// ************************************************
	// Assertions on faults, clears and answers
	// ************************************************
	sequence s_map_rd_fault;
		(hit_basic || hit_err) && rd_fault;
	endsequence
	sequence s_map_wr_fault;
		(hit_basic || hit_err) && wr_fault;
	endsequence
	sequence s_err_parity;
		hit_err && (rd_fault || wr_fault);
	endsequence
	sequence s_halt_basic;
		panel_halt_in || (hit_basic && pio_in.halt);
	endsequence
	sequence s_sys_cleared;
		!basic_status[BS_TEN] && !basic_status[BS_IEN] && !basic_status[BS_PSEL]
			&& !error_information[EI_PRIO];
	endsequence
	sequence s_quiet_answer;
		!pio_ack_out && !pio_refused_out && pio_rdata_out == 16'h0000;
	endsequence

	AST_RDCHK: assert property (s_map_rd_fault |=> error_information[EI_RDCHK])
		else $error("Read parity fault not flagged");
	AST_RD_EQCHK: assert property (hit_basic && rd_fault |=> basic_status[BS_EQCHK])
		else $error("Read parity on 08 left equipment check off");
	AST_WRCHK: assert property (s_map_wr_fault |=> error_information[EI_WRCHK])
		else $error("Write parity fault not flagged");
	AST_ADCHK_PAR: assert property (s_err_parity |=> error_information[EI_ADCHK])
		else $error("Parity fault on 0C not flagged");
	AST_EQCHK: assert property (s_halt_basic |=> basic_status[BS_EQCHK])
		else $error("Halt not flagged in basic status");
	AST_TCHK: assert property (tick && basic_status[BS_TEN] && basic_status[BS_TINT]
		|=> error_information[EI_TCHK])
		else $error("Missed timer interrupt not flagged");

	// Control bits only ever rise by program; the pushbutton drops them
	AST_SYS_CLEAR: assert property (sys_reset_in |=> s_sys_cleared)
		else $error("Hardware clear left control bits on");
	AST_IEN_ONLY_PROG: assert property ($rose(basic_status[BS_IEN])
		|-> $past(prog_basic))
		else $error("Interrupt enable rose without program");
	AST_PRIO_ONLY_PROG: assert property ($rose(error_information[EI_PRIO])
		|-> $past(prog_err))
		else $error("Priority control rose without program");
	AST_REQ_STAYS: assert property (basic_status[BS_IREQ] && !prog_basic
		&& !sys_reset_in |=> basic_status[BS_IREQ])
		else $error("Interrupt request dropped by itself");
	AST_PROG_REQ: assert property (prog_req || set_tint |=> basic_status[BS_IREQ])
		else $error("Request bit not raised");
	AST_SEC_GROUP: assert property (##1 sec_group_enable_out == $past(sec_grp_on))
		else $error("Group enable output wrong");

	// Writes never reach ROM; only low fetches and reads do
	AST_ROM_LOW: assert property (mem_req_in && !mem_write_in && !basic_status[BS_PSEL]
		&& mem_addr_in < ROM_LIMIT |=> mem_rom_sel_out)
		else $error("Low read not routed to ROM");
	AST_ROM_HIGH: assert property (mem_req_in && mem_addr_in >= ROM_LIMIT
		|=> !mem_rom_sel_out)
		else $error("High address routed to ROM");
	AST_MEM_VALID: assert property (mem_req_in |=> mem_valid_out)
		else $error("Storage request not answered");

	// Answers are registered, so each one is looked at one edge on
	AST_PIO_ACK: assert property (pio_in.valid |=> pio_ack_out)
		else $error("Request not acknowledged");
	AST_PIO_QUIET: assert property (!pio_in.valid |=> s_quiet_answer)
		else $error("Answer without request");
	AST_UNMAPPED: assert property (pio_in.valid && !any_map && !any_sec
		|=> pio_refused_out)
		else $error("Unmapped request not refused");
	AST_RD_BASIC: assert property (hit_basic && is_read
		|=> pio_rdata_out == $past(basic_status))
		else $error("Basic status read wrong");
endmodule
`default_nettype wire

// ==== src/scsr_pkg.sv ====
// Constants and carrier types for the system control status registers.
// Assumes one 200 MHz clock and programmed I/O requests of one cycle.
package scsr_pkg;
	// ************************************************
	// Addresses and commands
	// ************************************************
	localparam logic [7:0] ADDR_BASIC = 8'h08;
	localparam logic [7:0] ADDR_ERR = 8'h0C;
	localparam logic [7:0] ADDR_SEC_BASE = 8'h10;
	localparam int NUM_SEC = 4;
	typedef enum logic [2:0] {
		CMD_READ = 3'b000,
		CMD_WRITE = 3'b001,
		CMD_SET = 3'b010,
		CMD_RESET = 3'b011
	} scsr_cmd_t;
	typedef struct packed {
		logic valid;
		scsr_cmd_t cmd;
		logic [7:0] addr;
		logic [15:0] data;
		logic cmd_perr;
		logic wr_perr;
		logic rd_perr;
		logic halt;
	} scsr_pio_req_t;
	// ************************************************
	// Field positions and implemented-bit masks
	// ************************************************
	localparam int BS_POR = 3;
	localparam int BS_PSEL = 7;
	localparam int BS_TINT = 8;
	localparam int BS_TEN = 9;
	localparam int BS_EXPPWR = 11;
	localparam int BS_EQCHK = 13;
	localparam int BS_IEN = 14;
	localparam int BS_IREQ = 15;
	localparam int EI_PRIO = 1;
	localparam int EI_RDCHK = 4;
	localparam int EI_TCHK = 8;
	localparam int EI_WRCHK = 9;
	localparam int EI_SECCHK = 11;
	localparam int EI_ADCHK = 13;
	localparam int SU_GRP = 0;
	localparam int SU_ERR = 2;
	localparam int SU_EN = 3;
	localparam logic [15:0] BASIC_MASK = 16'hEB88;
	localparam logic [15:0] ERR_MASK = 16'h2B12;
	localparam logic [7:0] SEC_MASK = 8'h0D;
	localparam logic [15:0] BASIC_RESET = 16'h0008;
	localparam logic [15:0] ERR_RESET = 16'h0000;
	localparam logic [7:0] SEC_RESET = 8'h00;
	// ************************************************
	// Timing and storage routing
	// ************************************************
	localparam int TIMER_MS = 100;
	localparam int CLK_KHZ = 200000;
	localparam int TICK_CYCLES = TIMER_MS * CLK_KHZ;
	localparam logic [15:0] ROM_LIMIT = 16'h1000;
	localparam logic [1:0] PRIO_HIGH = 2'h0;
	localparam logic [1:0] PRIO_LOW = 2'h3;
	// Write, set or reset-under-mask applied to a register value
	function automatic logic [15:0] apply_cmd(input logic [15:0] cur, input scsr_cmd_t cmd,
		input logic [15:0] data);
		case (cmd)
			CMD_WRITE: apply_cmd = data;
			CMD_SET: apply_cmd = cur | data;
			CMD_RESET: apply_cmd = cur & ~data;
			default: apply_cmd = cur;
		endcase
	endfunction
endpackage

// ==== src/scsr_tick.sv ====
// 100 ms interval generator for the clocked interrupt.
// Assumes an asynchronous active-low reset already released cleanly.
`timescale 1ns/1ps
`default_nettype none
module scsr_tick import scsr_pkg::*; #(
	parameter int CYCLES = TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control and tick
	input wire logic run_in,
	output logic tick_out
);
	logic [31:0] count;
	wire logic last = (count == 32'(CYCLES - 1));
	// Restarts whenever the timer is disabled, so intervals count from enable
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count <= '0;
			tick_out <= 1'b0;
		end else begin
			count <= (!run_in || last) ? '0 : count + 32'h0000_0001;
			tick_out <= run_in && last;
		end
	end
endmodule
`default_nettype wire

// ==== src/scsr_sec_unit.sv ====
// Status register of one secondary control unit.
// Assumes the caller presents one decoded access pulse per request.
`timescale 1ns/1ps
`default_nettype none
module scsr_sec_unit import scsr_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Access from the primary unit
	input wire logic acc_in,
	input wire scsr_pio_req_t req_in,
	input wire logic array_perr_in,
	// State and verdict
	output logic [7:0] status_out,
	output logic ok_out
);
	wire logic invalid = req_in.cmd > CMD_RESET;
	wire logic is_read = req_in.cmd == CMD_READ;
	wire logic err_evt = array_perr_in || (acc_in && (req_in.cmd_perr || invalid
		|| (!is_read && req_in.wr_perr) || req_in.halt));
	// Blocked while in error, except the reset that clears it; reads need enable
	assign ok_out = acc_in && !err_evt && (status_out[SU_ERR] ? req_in.cmd == CMD_RESET
		: (!is_read || status_out[SU_EN]));
	wire logic [15:0] upd = apply_cmd({8'h00, status_out}, req_in.cmd, req_in.data);
	wire logic [7:0] next_status = ((ok_out ? upd[7:0] : status_out) & SEC_MASK)
		| (err_evt ? 8'(1 << SU_ERR) : 8'h00);
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_out <= SEC_RESET;
		end else begin
			status_out <= next_status;
		end
	end
endmodule
`default_nettype wire

// ==== test/scsr_host_model.sv ====
// Programmed I/O master that stands in for the processor.
// Assumes one caller at a time and answers registered one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module scsr_host_model import scsr_pkg::*; (
	// Clock and answer
	input wire logic clk_in,
	input wire logic ack_in,
	input wire logic refused_in,
	input wire logic [15:0] rdata_in,
	// Request
	output var scsr_pio_req_t pio_out
);
	initial begin
		pio_out = '0;
	end
	// ************************************************
	// One-cycle request strobe
	// ************************************************
	// The request lines change only through this task
	task automatic xfer(input scsr_cmd_t cmd, input logic [7:0] addr, input logic [15:0] data,
		input logic [3:0] flt, output logic [15:0] rd, output logic refd, output logic ackd);
		@(posedge clk_in);
		#1;
		pio_out = {1'b1, cmd, addr, data, flt};
		@(posedge clk_in);
		#1;
		ackd = ack_in;
		rd = rdata_in;
		refd = refused_in;
		// Released address and data lines flip so a stale value is never mistaken for live data
		pio_out = {1'b0, pio_out.cmd, ~addr, ~data, 4'h0};
	endtask
endmodule
`default_nettype wire

// ==== test/tb_system_control_status_regs.sv ====
// Self-checking bench for the system control status registers.
// Assumes scsr_top with a short tick and the host model as request master.
`timescale 1ns/1ps
`default_nettype none
module tb_system_control_status_regs import scsr_pkg::*;;
	logic ref_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [8:0] ev = '0;
	logic mem_req = 1'b0;
	logic mem_wr = 1'b0;
	logic [15:0] mem_addr = '0;
	scsr_pio_req_t programmed_io;
	logic ack, refused, irq, mem_valid, rom_sel;
	logic [15:0] rdata, basic, err;
	logic [1:0] prio;
	logic [NUM_SEC-1:0] grp;
	logic [15:0] rd_v;
	logic ref_v, ack_v;
	int err_total = 0;
	int n_compared = 0;
	localparam logic [7:0] SEC1 = ADDR_SEC_BASE + 8'h01;
	always #2.5 ref_clk_in = ~ref_clk_in;
	scsr_host_model host (.clk_in(ref_clk_in), .ack_in(ack), .refused_in(refused),
		.rdata_in(rdata), .pio_out(programmed_io));
	scsr_top #(.TICK_LEN(20)) uut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .pio_in(programmed_io),
		.pio_ack_out(ack), .pio_refused_out(refused), .pio_rdata_out(rdata),
		.sys_reset_in(ev[0]), .exp_power_lost_in(ev[1]), .panel_halt_in(ev[2]),
		.panel_rd_perr_in(ev[3]), .panel_wr_perr_in(ev[4]), .sec_array_perr_in(ev[8:5]),
		.mem_req_in(mem_req), .mem_write_in(mem_wr), .mem_addr_in(mem_addr),
		.mem_valid_out(mem_valid), .mem_rom_sel_out(rom_sel), .irq_out(irq),
		.prio_level_out(prio), .basic_status_out(basic), .error_information_out(err),
		.sec_group_enable_out(grp));
	// ************************************************
	// Shared tasks
	// ************************************************
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic pio_op(input scsr_cmd_t cmd, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] flt);
		host.xfer(cmd, a, d, flt, rd_v, ref_v, ack_v);
		check("ack", 16'(ack_v), 16'h0001);
	endtask
	task automatic rd(input logic [7:0] a);
		pio_op(CMD_READ, a, 16'h0000, 4'h0);
	endtask
	task automatic clear_all();
		pio_op(CMD_RESET, ADDR_BASIC, 16'hFFFF, 4'h0);
		pio_op(CMD_RESET, ADDR_ERR, 16'hFFFF, 4'h0);
	endtask
	task automatic pulse(input logic [8:0] m);
		@(posedge ref_clk_in);
		#1;
		ev = m;
		@(posedge ref_clk_in);
		#1;
		ev = '0;
	endtask
	task automatic fault(input scsr_cmd_t cmd, input logic [7:0] a, input logic [3:0] flt,
		input logic xref, input logic [15:0] xb, input logic [15:0] xe);
		clear_all();
		pio_op(cmd, a, 16'h0000, flt);
		check("fault refused", 16'(ref_v), 16'(xref));
		rd(ADDR_BASIC);
		check("fault basic 13", rd_v & 16'h2000, xb);
		rd(ADDR_ERR);
		check("fault error", rd_v, xe);
	endtask
	task automatic mem(input logic w, input logic [15:0] a, input logic exp);
		@(posedge ref_clk_in);
		#1;
		{mem_req, mem_wr, mem_addr} = {1'b1, w, a};
		@(posedge ref_clk_in);
		#1;
		mem_req = 1'b0;
		check("mem valid", 16'(mem_valid), 16'h0001);
		check("rom select", 16'(rom_sel), 16'(exp));
	endtask
	task automatic conclude();
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ************************************************
	// Tests
	// ************************************************
	initial begin
		repeat (8) @(posedge ref_clk_in);
		#1;
		nrst_in = 1'b1;
		repeat (3) @(posedge ref_clk_in);
		#1;
		check("basic reset", basic, BASIC_RESET);
		check("prio reset", 16'(prio), 16'(PRIO_LOW));
		rd(ADDR_BASIC);
		check("basic read", rd_v, 16'h0008);
		$display("Test reset done");
		pio_op(CMD_WRITE, ADDR_BASIC, 16'hFFFF, 4'h0);
		rd(ADDR_BASIC);
		check("basic mask", rd_v, 16'hEB88);
		check("irq on", 16'(irq), 16'h0001);
		pio_op(CMD_WRITE, ADDR_ERR, 16'hFFFF, 4'h0);
		rd(ADDR_ERR);
		check("error mask", rd_v, 16'h2B12);
		check("prio high", 16'(prio), 16'(PRIO_HIGH));
		pulse(9'h001);
		rd(ADDR_BASIC);
		check("hw clear", rd_v, 16'h0908);
		check("irq off", 16'(irq), 16'h0000);
		clear_all();
		rd(ADDR_BASIC);
		check("basic cleared", rd_v, 16'h0000);
		check("prio low", 16'(prio), 16'(PRIO_LOW));
		$display("Test masks done");
		pio_op(CMD_SET, ADDR_BASIC, 16'h0200, 4'h0);
		rd(ADDR_BASIC);
		check("timer on", rd_v, 16'h8300);
		pio_op(CMD_RESET, ADDR_BASIC, 16'h8100, 4'h0);
		repeat (21) @(posedge ref_clk_in);
		#1;
		check("tick bit 8", 16'(basic[8]), 16'h0001);
		check("tick bit 15", 16'(basic[15]), 16'h0001);
		repeat (21) @(posedge ref_clk_in);
		#1;
		check("timer check", 16'(err[8]), 16'h0001);
		clear_all();
		$display("Test timer done");
		pulse(9'h002);
		rd(ADDR_BASIC);
		check("power lost", rd_v, 16'h8800);
		clear_all();
		pio_op(CMD_SET, ADDR_BASIC, 16'h0800, 4'h0);
		rd(ADDR_BASIC);
		check("power set", rd_v, 16'h8800);
		$display("Test power done");
		fault(CMD_READ, ADDR_BASIC, 4'h1, 1'b0, 16'h2000, 16'h0000);
		fault(CMD_READ, ADDR_ERR, 4'h1, 1'b0, 16'h0000, 16'h2000);
		fault(CMD_READ, ADDR_BASIC, 4'h2, 1'b1, 16'h2000, 16'h0010);
		fault(CMD_READ, ADDR_ERR, 4'h2, 1'b1, 16'h0000, 16'h2010);
		fault(CMD_WRITE, ADDR_BASIC, 4'h4, 1'b1, 16'h2000, 16'h0200);
		fault(CMD_SET, ADDR_ERR, 4'h8, 1'b1, 16'h0000, 16'h2200);
		fault(scsr_cmd_t'(3'h4), ADDR_BASIC, 4'h0, 1'b1, 16'h0000, 16'h0000);
		clear_all();
		pulse(9'h004);
		rd(ADDR_BASIC);
		check("panel halt", rd_v, 16'h2000);
		clear_all();
		pulse(9'h018);
		rd(ADDR_ERR);
		check("panel parity", rd_v, 16'h0210);
		clear_all();
		$display("Test faults done");
		mem(1'b0, 16'h0FFF, 1'b1);
		mem(1'b0, 16'h1000, 1'b0);
		mem(1'b1, 16'h0000, 1'b0);
		pio_op(CMD_SET, ADDR_BASIC, 16'h0080, 4'h0);
		mem(1'b0, 16'h0000, 1'b0);
		clear_all();
		$display("Test storage done");
		rd(SEC1);
		check("sec read off", 16'(ref_v), 16'h0001);
		pio_op(CMD_WRITE, SEC1, 16'h00F9, 4'h0);
		rd(SEC1);
		check("sec value", rd_v, 16'h0009);
		check("sec read on", 16'(ref_v), 16'h0000);
		check("group enable", 16'(grp), 16'h0002);
		pio_op(CMD_WRITE, SEC1, 16'h0009, 4'h8);
		check("sec cmd perr", 16'(ref_v), 16'h0001);
		rd(SEC1);
		check("sec blocked", 16'(ref_v), 16'h0001);
		check("sec to error", 16'(err[11]), 16'h0001);
		pio_op(CMD_RESET, SEC1, 16'h0004, 4'h0);
		rd(SEC1);
		check("sec recovered", rd_v, 16'h0009);
		pulse(9'h040);
		rd(SEC1);
		check("sec array perr", 16'(ref_v), 16'h0001);
		pio_op(CMD_RESET, SEC1, 16'h0004, 4'h0);
		pio_op(scsr_cmd_t'(3'h4), SEC1, 16'h0000, 4'h0);
		check("sec invalid cmd", 16'(ref_v), 16'h0001);
		rd(SEC1);
		check("sec invalid blocks", 16'(ref_v), 16'h0001);
		$display("Test secondary done");
		conclude();
	end
	initial begin
		#20000;
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
